// [bench/dsr_car_model.sv]
`timescale 1ns/1ps
// Car controller side: watches the relay coils and times the pick pulse
module dsr_car_model (
    input wire logic clk, // Control clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire dsr_pkg::dsr_rly_s rly, // Relay coils from the drive
    output logic [15:0] pick_len // Cycles of the last pick pulse
);
    logic [15:0] cnt_q;

    // Count cycles with the pick coil energised, latch when it releases
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 16'h0000;
            pick_len <= 16'h0000;
        end else if (rly.brake_pick) begin
            cnt_q <= cnt_q + 16'h0001;
        end else if (cnt_q != 16'h0000) begin
            pick_len <= cnt_q;
            cnt_q <= 16'h0000;
        end
    end
endmodule

// [bench/dsr_top_tb.sv]
`timescale 1ns/1ps
// Self-checking bench for the status relay block
module dsr_top_tb;
    localparam logic [15:0] TK = 16'h0004;
    typedef struct packed {
        logic [15:0] spd;
        logic [15:0] fld;
        logic run;
        logic [4:0] exp;
    } dsr_row_s;
    logic clk;
    logic arst_n;
    dsr_pkg::dsr_apb_s apb;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    dsr_pkg::dsr_in_s din;
    dsr_pkg::dsr_rly_s rly;
    logic irq;
    logic [15:0] pick_len;
    logic [31:0] rd;
    logic er;
    int bad_count;
    int samples_checked;
    int cyc;
    dsr_row_s rows [6];

    dsr_top #(.TICK_CYC(TK)) u_dsr_top (
        .clk(clk), .arst_n(arst_n), .apb(apb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .din(din), .rly(rly),
        .irq(irq));

    dsr_car_model u_dsr_car_model (
        .clk(clk), .arst_n(arst_n), .rly(rly), .pick_len(pick_len));

    // Clock, 100 ns period
    always #50 clk = ~clk;

    // Compare one value and count it
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    // Closing report and verdict
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One APB transfer: setup, access until pready, then release
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                 pwdata: d};
        @(posedge clk);
        apb.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        apb <= '0;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        apb = '0;
        din = '0;
        rows[0] = '{16'h000f, 16'h0000, 1'b0, 5'b01001};
        rows[1] = '{16'h0010, 16'h0200, 1'b0, 5'b10001};
        rows[2] = '{16'h00ff, 16'h0201, 1'b0, 5'b10101};
        rows[3] = '{16'h0100, 16'h0000, 1'b1, 5'b10110};
        rows[4] = '{16'hffff, 16'h0000, 1'b0, 5'b10010};
        rows[5] = '{16'h0000, 16'h0000, 1'b0, 5'b01001};
        cycles(4);
        chk("rly_in_reset", 32'(rly), 32'(dsr_pkg::RLY_RST));
        chk("irq_in_reset", 32'(irq), 32'h0);
        @(posedge clk);
        arst_n <= 1'b1;
        // Setting words come up at their reset values
        for (int i = 0; i < dsr_pkg::NCFG; i++) begin
            xfer(1'b0, 8'(i * 4), 32'h0);
            chk("cfg_reset", rd, 32'(dsr_pkg::CFG_RST[i]));
        end
        // Compare rows: speed, zero speed and field-up relays
        foreach (rows[i]) begin
            @(posedge clk);
            din.spd_mag <= rows[i].spd;
            din.fld_cur <= rows[i].fld;
            din.drv_run <= rows[i].run;
            cycles(2);
            chk("cmp_relays", 32'(rly[4:0]),
                32'(rows[i].exp));
        end
        // Speed error persistence, 2 ms
        xfer(1'b1, dsr_pkg::OFS_ERR_TIME, 32'h2);
        cycles(1); // Let the persistence timer load the new length
        din.spd_err <= 16'h0041;
        cycles(6);
        chk("err_high_early", 32'(rly.err_high), 32'h0);
        cycles(8);
        chk("err_high", 32'(rly.err_high), 32'h1);
        chk("err_low", 32'(rly.err_low), 32'h0);
        din.spd_err <= 16'h0000;
        cycles(6);
        chk("err_low_early", 32'(rly.err_low), 32'h0);
        cycles(8);
        chk("err_low", 32'(rly.err_low), 32'h1);
        chk("err_high_back", 32'(rly.err_high), 32'h0);
        // Brake lift, 3 ms pick plus the closing edge, then a mid-pick drop
        xfer(1'b1, dsr_pkg::OFS_PICK_TIME, 32'h3);
        din.lift_req <= 1'b1;
        cycles(2);
        chk("lift_on", 32'(rly.lift_brake), 32'h1);
        chk("pick_on", 32'(rly.brake_pick), 32'h1);
        cycles(16);
        chk("pick_width", 32'(pick_len), 32'(3 * TK + 1));
        chk("lift_held", 32'(rly.lift_brake), 32'h1);
        din.lift_req <= 1'b0;
        cycles(2);
        din.lift_req <= 1'b1;
        cycles(4);
        din.lift_req <= 1'b0;
        cycles(2);
        chk("pick_drop", 32'(rly.brake_pick), 32'h0);
        chk("lift_drop", 32'(rly.lift_brake), 32'h0);
        // Supply relay with a 2 ms drop delay
        xfer(1'b1, dsr_pkg::OFS_SPR_DELAY, 32'h2);
        din.pwr_req <= 1'b1;
        cycles(2);
        chk("spr_on", 32'(rly.drive_supply_power_relay), 32'h1);
        din.pwr_req <= 1'b0;
        cycles(5);
        chk("spr_held", 32'(rly.drive_supply_power_relay), 32'h1);
        cycles(8);
        chk("spr_off", 32'(rly.drive_supply_power_relay), 32'h0);
        // Status word, events, mask and clear
        xfer(1'b0, dsr_pkg::OFS_STATUS, 32'h0);
        chk("status", rd, 32'h029);
        xfer(1'b0, dsr_pkg::OFS_INT_STAT, 32'h0);
        chk("int_stat", rd, 32'h00f);
        chk("irq_masked", 32'(irq), 32'h0);
        xfer(1'b1, dsr_pkg::OFS_INT_MASK, 32'hf);
        cycles(1);
        chk("irq_on", 32'(irq), 32'h1);
        xfer(1'b1, dsr_pkg::OFS_INT_STAT, 32'hf);
        cycles(1);
        chk("irq_clear", 32'(irq), 32'h0);
        xfer(1'b0, dsr_pkg::OFS_INT_MASK, 32'h0);
        chk("int_mask", rd, 32'h00f);
        // Unmapped address is refused
        xfer(1'b1, 8'h30, 32'h5);
        chk("slverr_wr", 32'(er), 32'h1);
        xfer(1'b0, 8'h30, 32'h0);
        chk("slverr_rd", 32'(er), 32'h1);
        chk("unmapped_rd", rd, 32'h0);
        end_of_test();
    end
endmodule

// [rtl/dsr_pkg.sv]
// Summary of operation
// - Low speed is active while encoder speed is below the low threshold.
// - High speed is active otherwise; always the complement of low speed.
// - Field-up is active above the field threshold or while running.
// - Error-low sets after error stays below threshold past persistence.
// - Error-high sets after error stays above threshold; inverse of low.
// - Zero speed is active while encoder speed is below zero threshold.
// - Moving is active otherwise; always the complement of zero speed.
// - Lift-brake output follows the brake lift request.
// - Brake pick pulses for the pick time at each lift start.
// - Brake pick drops at once when the brake is to be dropped.
// - Supply power relay is on while power-up is requested.
// - Supply power relay drops after its delay timer runs out.
package dsr_pkg;

    // Clock and millisecond tick timing
    localparam int CLK_NS = 100;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;

    // Register byte offsets
    localparam logic [7:0] OFS_LOW_SPD = 8'h00;
    localparam logic [7:0] OFS_ZERO_SPD = 8'h04;
    localparam logic [7:0] OFS_FLD_THR = 8'h08;
    localparam logic [7:0] OFS_ERR_THR = 8'h0c;
    localparam logic [7:0] OFS_ERR_TIME = 8'h10;
    localparam logic [7:0] OFS_PICK_TIME = 8'h14;
    localparam logic [7:0] OFS_SPR_DELAY = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_INT_STAT = 8'h20;
    localparam logic [7:0] OFS_INT_MASK = 8'h24;

    // Register indices; the first seven are the setting words
    localparam logic [3:0] IX_LOW = 4'h0;
    localparam logic [3:0] IX_ZERO = 4'h1;
    localparam logic [3:0] IX_FLD = 4'h2;
    localparam logic [3:0] IX_ERR = 4'h3;
    localparam logic [3:0] IX_ERRT = 4'h4;
    localparam logic [3:0] IX_PICK = 4'h5;
    localparam logic [3:0] IX_SPR = 4'h6;
    localparam logic [3:0] IX_STATUS = 4'h7;
    localparam logic [3:0] IX_ISTAT = 4'h8;
    localparam logic [3:0] IX_IMASK = 4'h9;
    localparam logic [3:0] IX_NONE = 4'hf;
    localparam int NCFG = 7;

    // Setting reset values, index 6 down to 0
    localparam logic [NCFG-1:0][15:0] CFG_RST = {
        16'h1388, 16'h01f4, 16'h0064, 16'h0040,
        16'h0200, 16'h0010, 16'h0100};

    // Interrupt bit positions
    localparam int NIRQ = 4;
    localparam int IRQ_PICK_END = 0;
    localparam int IRQ_SPR_OFF = 1;
    localparam int IRQ_ERR_HI = 2;
    localparam int IRQ_ZERO = 3;

    // Brake sequence states, Gray along idle, pick, hold
    typedef enum logic [1:0] {
        BRK_IDLE = 2'b00,
        BRK_PICK = 2'b01,
        BRK_HOLD = 2'b11
    } dsr_brk_e;

    // Relay outputs; also the status register layout from bit 0
    typedef struct packed {
        logic drive_supply_power_relay;
        logic brake_pick;
        logic lift_brake;
        logic err_high;
        logic err_low;
        logic moving;
        logic zero_spd;
        logic field_up;
        logic high_spd;
        logic low_spd;
    } dsr_rly_s;

    // Relay levels in reset: low speed, zero speed and error low, pairs kept
    localparam dsr_rly_s RLY_RST = '{low_spd: 1'b1, zero_spd: 1'b1,
        err_low: 1'b1, default: 1'b0};

    // Measurements and commands from the control loop
    typedef struct packed {
        logic [15:0] spd_mag;
        logic [15:0] spd_err;
        logic [15:0] fld_cur;
        logic drv_run;
        logic lift_req;
        logic pwr_req;
    } dsr_in_s;

    // APB request signals
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } dsr_apb_s;

    // Timer state
    typedef struct packed {
        logic [15:0] ms;
        logic [15:0] pre;
    } dsr_tmr_s;

    // Top-level state
    typedef struct packed {
        logic [NCFG-1:0][15:0] cfg;
        logic [NIRQ-1:0] int_stat;
        logic [NIRQ-1:0] int_mask;
        logic [31:0] prdata;
        dsr_rly_s rly;
        dsr_brk_e brk;
        logic err_hi;
    } dsr_st_s;

endpackage

// [rtl/dsr_timer.sv]
`timescale 1ns/1ps
// Millisecond down-counter; reloads while load is high
module dsr_timer #(
    parameter logic [15:0] TICK_CYC = 16'(dsr_pkg::TICK_CYC)
) (
    input wire logic clk, // Control clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic load, // Restart with len
    input wire logic [15:0] len, // Length in milliseconds
    output logic expired // Count has reached zero
);

    dsr_pkg::dsr_tmr_s q;
    dsr_pkg::dsr_tmr_s d;

    // Prescale to milliseconds, then count down to zero
    always_comb begin
        d = q;
        if (load) begin
            d.ms = len;
            d.pre = 16'h0000;
        end else if (q.ms != 16'h0000) begin
            if (q.pre >= TICK_CYC - 16'h0001) begin
                d.pre = 16'h0000;
                d.ms = q.ms - 16'h0001;
            end else begin
                d.pre = q.pre + 16'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign expired = (q.ms == 16'h0000);

endmodule

// [rtl/dsr_top.sv]
`timescale 1ns/1ps
// Status relay outputs of the drive with an APB register file
module dsr_top #(
    parameter logic [15:0] TICK_CYC = 16'(dsr_pkg::TICK_CYC)
) (
    input wire logic clk, // Control clock, 10 MHz
    input wire logic arst_n, // Asynchronous reset, active low
    input wire dsr_pkg::dsr_apb_s apb, // APB request
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error on unmapped address
    input wire dsr_pkg::dsr_in_s din, // Control loop inputs
    output dsr_pkg::dsr_rly_s rly, // Relay outputs
    output logic irq // Level interrupt
);

    dsr_pkg::dsr_st_s q;
    dsr_pkg::dsr_st_s d;

    logic cmp_low;
    logic cmp_zero;
    logic cmp_fld;
    logic cmp_elo;
    logic cmp_ehi;
    logic err_load;
    logic err_exp;
    logic pick_exp;
    logic spr_exp;
    logic wr_acc;
    logic rd_setup;
    logic [3:0] wr_ix;
    logic [3:0] rd_ix;
    logic [dsr_pkg::NIRQ-1:0] ev;
    logic [dsr_pkg::NIRQ-1:0] w1c;

    // Map a byte address to a register index
    function automatic logic [3:0] reg_idx(input logic [7:0] a);
        logic [3:0] ix;
        ix = dsr_pkg::IX_NONE;
        if (a == dsr_pkg::OFS_LOW_SPD) begin
            ix = dsr_pkg::IX_LOW;
        end else if (a == dsr_pkg::OFS_ZERO_SPD) begin
            ix = dsr_pkg::IX_ZERO;
        end else if (a == dsr_pkg::OFS_FLD_THR) begin
            ix = dsr_pkg::IX_FLD;
        end else if (a == dsr_pkg::OFS_ERR_THR) begin
            ix = dsr_pkg::IX_ERR;
        end else if (a == dsr_pkg::OFS_ERR_TIME) begin
            ix = dsr_pkg::IX_ERRT;
        end else if (a == dsr_pkg::OFS_PICK_TIME) begin
            ix = dsr_pkg::IX_PICK;
        end else if (a == dsr_pkg::OFS_SPR_DELAY) begin
            ix = dsr_pkg::IX_SPR;
        end else if (a == dsr_pkg::OFS_STATUS) begin
            ix = dsr_pkg::IX_STATUS;
        end else if (a == dsr_pkg::OFS_INT_STAT) begin
            ix = dsr_pkg::IX_ISTAT;
        end else if (a == dsr_pkg::OFS_INT_MASK) begin
            ix = dsr_pkg::IX_IMASK;
        end
        return ix;
    endfunction

    // Threshold compares, once per clock
    assign cmp_low = din.spd_mag < q.cfg[dsr_pkg::IX_LOW];
    assign cmp_zero = din.spd_mag < q.cfg[dsr_pkg::IX_ZERO];
    assign cmp_fld = din.fld_cur > q.cfg[dsr_pkg::IX_FLD];
    assign cmp_elo = din.spd_err < q.cfg[dsr_pkg::IX_ERR];
    assign cmp_ehi = din.spd_err > q.cfg[dsr_pkg::IX_ERR];

    // Error persistence restarts while the opposite condition is absent
    assign err_load = q.err_hi ? !cmp_elo : !cmp_ehi;

    // Error persistence timer
    dsr_timer #(
        .TICK_CYC(TICK_CYC)
    ) u_err_tmr (
        .clk(clk),
        .arst_n(arst_n),
        .load(err_load),
        .len(q.cfg[dsr_pkg::IX_ERRT]),
        .expired(err_exp)
    );

    // Brake pick timer, armed while the brake is down
    dsr_timer #(
        .TICK_CYC(TICK_CYC)
    ) u_pick_tmr (
        .clk(clk),
        .arst_n(arst_n),
        .load(q.brk == dsr_pkg::BRK_IDLE),
        .len(q.cfg[dsr_pkg::IX_PICK]),
        .expired(pick_exp)
    );

    // Supply relay delay timer, held while power-up is requested
    dsr_timer #(
        .TICK_CYC(TICK_CYC)
    ) u_spr_tmr (
        .clk(clk),
        .arst_n(arst_n),
        .load(din.pwr_req),
        .len(q.cfg[dsr_pkg::IX_SPR]),
        .expired(spr_exp)
    );

    // APB access decode
    assign wr_acc = apb.psel && apb.penable && apb.pwrite;
    assign rd_setup = apb.psel && !apb.penable && !apb.pwrite;
    assign wr_ix = reg_idx(apb.paddr);
    assign rd_ix = wr_ix;

    // Write-one-to-clear mask for interrupt status
    assign w1c = (wr_acc && wr_ix == dsr_pkg::IX_ISTAT) ?
        apb.pwdata[dsr_pkg::NIRQ-1:0] : '0;

    // Next state of relays, brake sequence, registers and interrupts
    always_comb begin
        d = q;
        ev = '0;

        // Speed and field relays
        d.rly.low_spd = cmp_low;
        d.rly.high_spd = !cmp_low;
        d.rly.zero_spd = cmp_zero;
        d.rly.moving = !cmp_zero;
        d.rly.field_up = cmp_fld || din.drv_run;

        // Speed error state flips once persistence has run out
        if (!err_load && err_exp) begin
            d.err_hi = !q.err_hi;
        end
        d.rly.err_high = d.err_hi;
        d.rly.err_low = !d.err_hi;

        // Brake lift sequence
        case (q.brk)
            dsr_pkg::BRK_IDLE: begin
                if (din.lift_req) begin
                    d.brk = dsr_pkg::BRK_PICK;
                end
            end
            dsr_pkg::BRK_PICK: begin
                if (!din.lift_req) begin
                    d.brk = dsr_pkg::BRK_IDLE;
                end else if (pick_exp) begin
                    d.brk = dsr_pkg::BRK_HOLD;
                end
            end
            dsr_pkg::BRK_HOLD: begin
                if (!din.lift_req) begin
                    d.brk = dsr_pkg::BRK_IDLE;
                end
            end
            default: begin
                d.brk = dsr_pkg::BRK_IDLE;
            end
        endcase
        d.rly.lift_brake = d.brk != dsr_pkg::BRK_IDLE;
        d.rly.brake_pick = d.brk == dsr_pkg::BRK_PICK;

        // Supply relay: on with the request, off after the delay
        if (din.pwr_req) begin
            d.rly.drive_supply_power_relay = 1'b1;
        end else if (spr_exp) begin
            d.rly.drive_supply_power_relay = 1'b0;
        end

        // Events
        ev[dsr_pkg::IRQ_PICK_END] = q.brk == dsr_pkg::BRK_PICK &&
            d.brk == dsr_pkg::BRK_HOLD;
        ev[dsr_pkg::IRQ_SPR_OFF] = q.rly.drive_supply_power_relay &&
            !d.rly.drive_supply_power_relay;
        ev[dsr_pkg::IRQ_ERR_HI] = !q.err_hi && d.err_hi;
        ev[dsr_pkg::IRQ_ZERO] = !q.rly.zero_spd && d.rly.zero_spd;

        // Register writes at the access phase
        if (wr_acc) begin
            if (wr_ix < 4'(dsr_pkg::NCFG)) begin
                d.cfg[wr_ix[2:0]] = apb.pwdata[15:0];
            end else if (wr_ix == dsr_pkg::IX_IMASK) begin
                d.int_mask = apb.pwdata[dsr_pkg::NIRQ-1:0];
            end
        end

        // Sticky status; a new event wins over a clear
        d.int_stat = (q.int_stat & ~w1c) | ev;

        // Read data captured in the setup phase
        if (rd_setup) begin
            d.prdata = 32'h0000_0000;
            if (rd_ix < 4'(dsr_pkg::NCFG)) begin
                d.prdata[15:0] = q.cfg[rd_ix[2:0]];
            end else if (rd_ix == dsr_pkg::IX_STATUS) begin
                d.prdata[9:0] = q.rly;
            end else if (rd_ix == dsr_pkg::IX_ISTAT) begin
                d.prdata[dsr_pkg::NIRQ-1:0] = q.int_stat;
            end else if (rd_ix == dsr_pkg::IX_IMASK) begin
                d.prdata[dsr_pkg::NIRQ-1:0] = q.int_mask;
            end
        end
    end

    // State register; rly, prdata and irq change on the clock edge, pslverr is combinational
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q.cfg <= dsr_pkg::CFG_RST;
            q.int_stat <= '0;
            q.int_mask <= '0;
            q.prdata <= 32'h0000_0000;
            q.rly <= dsr_pkg::RLY_RST;
            q.brk <= dsr_pkg::BRK_IDLE;
            q.err_hi <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // Bus answers and outputs
    assign pready = 1'b1;
    assign pslverr = apb.psel && apb.penable && (wr_ix == dsr_pkg::IX_NONE);
    assign prdata = q.prdata;
    assign rly = q.rly;
    assign irq = |(q.int_stat & q.int_mask);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // Lift request seen while the brake is down
    sequence s_lift_start;
        q.brk == dsr_pkg::BRK_IDLE && din.lift_req;
    endsequence

    // Pick and lift relay outputs both on in the same cycle
    sequence s_pick_on;
        rly.brake_pick && rly.lift_brake;
    endsequence

    // Persistence restarted or still running: no flip allowed
    sequence s_err_wait;
        err_load || !err_exp;
    endsequence

    // Supply relay on with its drop delay still running
    sequence s_supply_wait;
        rly.drive_supply_power_relay && !spr_exp;
    endsequence

    a_low_speed_cmp: assert property (
        rly.low_spd == $past(cmp_low))
        else $error("low speed does not follow compare");

    a_high_low_pair: assert property (
        rly.high_spd == !rly.low_spd)
        else $error("high speed not complement of low speed");

    a_field_up_cause: assert property (
        $past(din.drv_run) |-> rly.field_up)
        else $error("field up missing while running");

    a_err_rise_cause: assert property (
        $rose(rly.err_high) |-> $past(cmp_ehi) && $past(err_exp))
        else $error("error high set without persistence");

    a_err_fall_cause: assert property (
        $rose(rly.err_low) |-> $past(cmp_elo) && $past(err_exp))
        else $error("error low set without persistence");

    a_err_pair_inv: assert property (
        rly.err_low == !rly.err_high)
        else $error("error outputs not inverse");

    a_zero_moving_pair: assert property (
        rly.zero_spd == !rly.moving && rly.zero_spd == $past(cmp_zero))
        else $error("zero speed or moving wrong");

    a_lift_follow_req: assert property (
        rly.lift_brake == $past(din.lift_req))
        else $error("lift brake does not follow request");

    a_pick_start_seq: assert property (
        s_lift_start |=> s_pick_on)
        else $error("brake pick did not start with lift");

    a_pick_drop_now: assert property (
        !din.lift_req |=> !rly.brake_pick && !rly.lift_brake)
        else $error("brake pick held after drop");

    a_pick_end_timed: assert property (
        $fell(rly.brake_pick) |-> $past(pick_exp) || !$past(din.lift_req))
        else $error("brake pick ended early");

    a_supply_on_req: assert property (
        din.pwr_req |=> rly.drive_supply_power_relay)
        else $error("supply relay off while requested");

    a_supply_off_delay: assert property (
        $fell(rly.drive_supply_power_relay) |->
            $past(spr_exp) && !$past(din.pwr_req))
        else $error("supply relay dropped before delay");

    a_irq_stat_set: assert property (
        ev != '0 |=> (q.int_stat & $past(ev)) == $past(ev))
        else $error("event lost in interrupt status");

    // Remaining relay levels against the compares of the edge before, then the error, pick and supply hold rules
    a_high_speed_cmp: assert property (
        rly.high_spd == !$past(cmp_low))
        else $error("high speed does not follow compare");

    a_field_up_cmp: assert property (
        rly.field_up == ($past(cmp_fld) || $past(din.drv_run)))
        else $error("field up does not follow compare");

    a_moving_cmp: assert property (
        rly.moving == !$past(cmp_zero))
        else $error("moving does not follow compare");

    a_err_hold_state: assert property (
        s_err_wait |=> $stable(rly.err_high))
        else $error("error state changed before persistence");

    a_pick_in_lift: assert property (
        rly.brake_pick |-> rly.lift_brake)
        else $error("brake pick on without lift");

    a_supply_hold_delay: assert property (
        s_supply_wait |=> rly.drive_supply_power_relay)
        else $error("supply relay dropped while delay runs");

    // Every relay event leaves its sticky status bit set
    a_zero_event_stat: assert property (
        $rose(rly.zero_spd) |-> q.int_stat[dsr_pkg::IRQ_ZERO])
        else $error("zero speed event not in status");

    a_pick_event_stat: assert property (
        $fell(rly.brake_pick) && rly.lift_brake |->
            q.int_stat[dsr_pkg::IRQ_PICK_END])
        else $error("pick end event not in status");

    a_supply_event_stat: assert property (
        $fell(rly.drive_supply_power_relay) |->
            q.int_stat[dsr_pkg::IRQ_SPR_OFF])
        else $error("supply drop event not in status");

    a_err_event_stat: assert property (
        $rose(rly.err_high) |-> q.int_stat[dsr_pkg::IRQ_ERR_HI])
        else $error("error high event not in status");

endmodule
